// [tlpi_pkg.sv]
// Package for the two-level priority interrupt unit: register map, fields, vectors, states
package tlpi_pkg;
	// APB byte offsets of the registers
	localparam logic [7:0] ADDR_MAIN_CTRL = 8'h00;
	localparam logic [7:0] ADDR_EDGE_PRIO = 8'h04;
	localparam logic [7:0] ADDR_EXT_CTRL = 8'h08;
	localparam logic [7:0] ADDR_RESET_CTRL = 8'h0C;
	localparam logic [7:0] ADDR_PORT_B = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	// Main control fields
	localparam int MC_GIE = 7;
	localparam int MC_PERIPHERAL_IRQ_ENABLE = 6;
	localparam int MC_T0IE = 5;
	localparam int MC_P0IE = 4;
	localparam int MC_PORT_CHANGE_ENABLE = 3;
	localparam int MC_T0IF = 2;
	localparam int MC_P0IF = 1;
	localparam int MC_PORT_CHANGE_FLAG = 0;
	// Edge and priority fields
	localparam int EP_PUDIS = 7;
	localparam int EP_EDG0 = 6;
	localparam int EP_EDG1 = 5;
	localparam int EP_EDG2 = 4;
	localparam int EP_T0IP = 2;
	localparam int EP_PORT_CHANGE_PRIORITY = 0;
	// External pin control fields
	localparam int EX_P2IP = 7;
	localparam int EX_P1IP = 6;
	localparam int EX_P2IE = 4;
	localparam int EX_P1IE = 3;
	localparam int EX_P2IF = 1;
	localparam int EX_P1IF = 0;
	localparam int RC_PRIORITY_LEVELS_ENABLE = 7;
	// Reset values and write masks
	localparam logic [7:0] MAIN_RESET = 8'h00;
	localparam logic [7:0] EDGE_PRIO_RESET = 8'hF5;
	localparam logic [7:0] EXT_RESET = 8'hC0;
	localparam logic [7:0] EDGE_PRIO_MASK = 8'hF5;
	localparam logic [7:0] EXT_MASK = 8'hDB;
	localparam logic [7:0] RESET_CTRL_MASK = 8'h80;
	// Vectors
	localparam logic [20:0] VEC_HIGH = 21'h00_0008;
	localparam logic [20:0] VEC_LOW = 21'h00_0018;
	// Wait cycles counted after a request pends, before the vector request
	localparam logic [1:0] EXT_DELAY = 2'h2;
	typedef enum logic [2:0] {
		TLPI_IDLE = 3'b001,
		TLPI_LOW = 3'b010,
		TLPI_HIGH = 3'b100
	} tlpi_state_type;
endpackage : tlpi_pkg

// [tlpi_ctrl.sv]
// Two-level priority interrupt unit with APB register access
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - High vector is 000008h, low vector is 000018h.
// - Priority levels active only when reset-control bit 7 set; clear at reset.
// - Priority mode: main control bit 7 enables high priority sources.
// - Priority mode: main control bit 6 enables low priority sources.
// - Flag, enable and global enable set: vector to level chosen by priority.
// - Compatibility mode ignores priorities; every request goes to 000008h.
// - Compatibility mode: bit 6 gates peripherals, bit 7 gates everything. Here bit 6 gates nothing; bit 7 alone gates all sources.
// - Accepting an interrupt clears the global enable of its path.
// - High preempts low service; low never taken during high service.
// - Accept pushes return address and loads vector into program counter.
// - Return instruction leaves service and sets the matching global enable.
// - Pin and port-change events vector three to four cycles later.
// - Flags set on events regardless of any enable.
// - External pin zero has no priority bit and is always high.
// - Port-change flag set while upper port pins mismatch; port read ends it.
// - Edge-select one picks rising edges, zero falling; all reset to one.
// - Pull-up disable bit one kills pull-ups; zero follows port latches.
// - Priority mode: high enable clear blocks all; low clear blocks low only.
// - Priority bit one is high, zero low; reset to one.
module tlpi_ctrl
	import tlpi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer0_overflow,
	input wire logic ext_irq_pin0,
	input wire logic ext_irq_pin1,
	input wire logic ext_irq_pin2,
	input wire logic [3:0] upper_port_b_pins,
	input wire logic [3:0] port_b_latch,
	input wire logic irq_ack,
	input wire logic return_from_irq_instruction,
	input wire logic [20:0] return_address,
	output logic irq_request,
	output logic [20:0] irq_vector,
	output logic stack_push,
	output logic [20:0] stack_push_data,
	output logic [3:0] port_pullup_enable
);
	logic [7:0] main_interrupt_control, next_main;
	logic [7:0] edge_and_priority_control, next_edge;
	logic [7:0] external_pin_interrupt_control, next_ext;
	logic [7:0] reset_control_register, next_reset_control_register;
	logic [2:0] pin_prev, next_pin_prev;
	logic [3:0] port_snap, next_port_snap;
	logic [1:0] ext_wait, next_ext_wait;
	tlpi_state_type state, next_state;
	logic low_preempted, next_low_preempted;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr, next_irq_request, next_stack_push;
	logic [20:0] next_irq_vector, next_stack_push_data;
	logic [3:0] next_pullup;
	logic [2:0] pin_edge;
	logic port_mismatch, high_pend, low_pend, apb_wr, apb_rd;
	function automatic logic edge_hit(input logic prev, input logic now, input logic rising);
		edge_hit = rising ? (!prev && now) : (prev && !now);
	endfunction : edge_hit

	always_comb begin
		// Writes and port reads act only at the edge that completes the transfer
		apb_wr = psel && penable && pwrite && pready;
		apb_rd = psel && penable && !pwrite && pready;
		pin_edge[0] = edge_hit(pin_prev[0], ext_irq_pin0, edge_and_priority_control[EP_EDG0]);
		pin_edge[1] = edge_hit(pin_prev[1], ext_irq_pin1, edge_and_priority_control[EP_EDG1]);
		pin_edge[2] = edge_hit(pin_prev[2], ext_irq_pin2, edge_and_priority_control[EP_EDG2]);
		port_mismatch = (upper_port_b_pins != port_snap);
	end

	// Registers and flags
	always_comb begin
		next_main = main_interrupt_control;
		next_edge = edge_and_priority_control;
		next_ext = external_pin_interrupt_control;
		next_reset_control_register = reset_control_register;
		next_port_snap = port_snap;
		next_pin_prev = {ext_irq_pin2, ext_irq_pin1, ext_irq_pin0};
		if (apb_wr) begin
			case (paddr)
				ADDR_MAIN_CTRL: next_main = pwdata[7:0];
				ADDR_EDGE_PRIO: next_edge = pwdata[7:0] & EDGE_PRIO_MASK;
				ADDR_EXT_CTRL: next_ext = pwdata[7:0] & EXT_MASK;
				ADDR_RESET_CTRL: next_reset_control_register = pwdata[7:0] & RESET_CTRL_MASK;
				default: next_reset_control_register = reset_control_register;
			endcase
		end
		if (apb_rd && paddr == ADDR_PORT_B)
			next_port_snap = upper_port_b_pins;
		// Accept clears the used global enable
		if (irq_ack && irq_request) begin
			if (!reset_control_register[RC_PRIORITY_LEVELS_ENABLE] || irq_vector == VEC_HIGH)
				next_main[MC_GIE] = 1'b0;
			else
				next_main[MC_PERIPHERAL_IRQ_ENABLE] = 1'b0;
		end
		// Return sets the matching global enable
		if (return_from_irq_instruction) begin
			if (!reset_control_register[RC_PRIORITY_LEVELS_ENABLE] || state == TLPI_HIGH && !low_preempted)
				next_main[MC_GIE] = 1'b1;
			else if (state == TLPI_LOW)
				next_main[MC_PERIPHERAL_IRQ_ENABLE] = 1'b1;
			else
				next_main[MC_GIE] = 1'b1;
		end
		// Flag sets win over software clears
		if (timer0_overflow)
			next_main[MC_T0IF] = 1'b1;
		if (pin_edge[0])
			next_main[MC_P0IF] = 1'b1;
		if (port_mismatch && !(apb_rd && paddr == ADDR_PORT_B))
			next_main[MC_PORT_CHANGE_FLAG] = 1'b1;
		if (pin_edge[1])
			next_ext[EX_P1IF] = 1'b1;
		if (pin_edge[2])
			next_ext[EX_P2IF] = 1'b1;
	end

	// Request qualification
	always_comb begin
		logic [4:0] act, pri;
		logic any_act;
		act = {main_interrupt_control[MC_T0IF] & main_interrupt_control[MC_T0IE],
			main_interrupt_control[MC_P0IF] & main_interrupt_control[MC_P0IE],
			main_interrupt_control[MC_PORT_CHANGE_FLAG] & main_interrupt_control[MC_PORT_CHANGE_ENABLE],
			external_pin_interrupt_control[EX_P1IF] & external_pin_interrupt_control[EX_P1IE],
			external_pin_interrupt_control[EX_P2IF] & external_pin_interrupt_control[EX_P2IE]};
		// Pin zero fixed high; one means high
		pri = {edge_and_priority_control[EP_T0IP], 1'b1, edge_and_priority_control[EP_PORT_CHANGE_PRIORITY],
			external_pin_interrupt_control[EX_P1IP], external_pin_interrupt_control[EX_P2IP]};
		any_act = |act;
		if (reset_control_register[RC_PRIORITY_LEVELS_ENABLE]) begin
			// High sources gated by bit 7
			high_pend = main_interrupt_control[MC_GIE] && |(act & pri);
			// Low sources gated by bit 6
			low_pend = main_interrupt_control[MC_GIE] && main_interrupt_control[MC_PERIPHERAL_IRQ_ENABLE]
				&& |(act & ~pri);
		end else begin
			// Priorities ignored; every source needs only bit 7, bit 6 unused
			high_pend = main_interrupt_control[MC_GIE] && any_act;
			low_pend = 1'b0;
		end
	end

	// Service sequencing toward the core
	always_comb begin
		next_state = state;
		next_low_preempted = low_preempted;
		next_irq_request = irq_request;
		next_irq_vector = irq_vector;
		next_stack_push = 1'b0;
		next_stack_push_data = stack_push_data;
		next_ext_wait = ext_wait;
		if (irq_request && irq_ack) begin
			// Push return address, jump to vector
			next_irq_request = 1'b0;
			next_stack_push = 1'b1;
			next_stack_push_data = return_address;
			if (irq_vector == VEC_HIGH) begin
				next_low_preempted = (state == TLPI_LOW);
				next_state = TLPI_HIGH;
			end else begin
				next_state = TLPI_LOW;
			end
			next_ext_wait = 2'h0;
		end else if (return_from_irq_instruction) begin
			next_state = (state == TLPI_HIGH && low_preempted) ? TLPI_LOW : TLPI_IDLE;
			next_low_preempted = 1'b0;
		end else if (!irq_request) begin
			// Fixed wait gives even latency whatever the instruction length
			if ((high_pend && state != TLPI_HIGH) || (low_pend && state == TLPI_IDLE)) begin
				if (ext_wait != EXT_DELAY)
					next_ext_wait = ext_wait + 2'h1;
				else begin
					next_irq_request = 1'b1;
					// High preempts low; high wins a tie
					next_irq_vector = (high_pend && state != TLPI_HIGH) ? VEC_HIGH : VEC_LOW;
				end
			end else
				next_ext_wait = 2'h0;
		end
		case (state)
			TLPI_IDLE, TLPI_LOW, TLPI_HIGH: next_pullup = {4{!edge_and_priority_control[EP_PUDIS]}};
			default: next_pullup = 4'h0;
		endcase
		next_pullup = next_pullup & port_b_latch;
	end

	// APB slave, one wait state, error on unmapped addresses
	always_comb begin
		next_pready = psel && penable && !pready;
		next_pslverr = 1'b0;
		next_prdata = 32'h0000_0000;
		if (psel && penable && !pready) begin
			case (paddr)
				ADDR_MAIN_CTRL: next_prdata = {24'h00_0000, main_interrupt_control};
				ADDR_EDGE_PRIO: next_prdata = {24'h00_0000, edge_and_priority_control};
				ADDR_EXT_CTRL: next_prdata = {24'h00_0000, external_pin_interrupt_control};
				ADDR_RESET_CTRL: next_prdata = {24'h00_0000, reset_control_register};
				ADDR_PORT_B: next_prdata = {28'h000_0000, upper_port_b_pins};
				ADDR_STATUS: next_prdata = {29'h0000_0000, state};
				default: next_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			// Priority levels off; edge and priority bits set
			main_interrupt_control <= MAIN_RESET;
			edge_and_priority_control <= EDGE_PRIO_RESET;
			external_pin_interrupt_control <= EXT_RESET;
			reset_control_register <= 8'h00;
			pin_prev <= 3'h0;
			port_snap <= 4'h0;
			ext_wait <= 2'h0;
			state <= TLPI_IDLE;
			low_preempted <= 1'b0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq_request <= 1'b0;
			irq_vector <= VEC_HIGH;
			stack_push <= 1'b0;
			stack_push_data <= 21'h00_0000;
			port_pullup_enable <= 4'h0;
		end else begin
			main_interrupt_control <= next_main;
			edge_and_priority_control <= next_edge;
			external_pin_interrupt_control <= next_ext;
			reset_control_register <= next_reset_control_register;
			pin_prev <= next_pin_prev;
			port_snap <= next_port_snap;
			ext_wait <= next_ext_wait;
			state <= next_state;
			low_preempted <= next_low_preempted;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			irq_request <= next_irq_request;
			irq_vector <= next_irq_vector;
			stack_push <= next_stack_push;
			stack_push_data <= next_stack_push_data;
			port_pullup_enable <= next_pullup;
		end
	end

	a_flag_timer0: assert property (@(posedge sys_clk) disable iff (!reset_n)
		timer0_overflow |=> main_interrupt_control[MC_T0IF])
		else $error("timer flag not set");
	a_compat_vector: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(irq_request && !reset_control_register[RC_PRIORITY_LEVELS_ENABLE]) |-> irq_vector == VEC_HIGH)
		else $error("compat vector wrong");
	a_accept_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(irq_request && irq_ack && irq_vector == VEC_HIGH && !return_from_irq_instruction)
		|=> !main_interrupt_control[MC_GIE])
		else $error("global enable not cleared");
	a_push_addr: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(irq_request && irq_ack) |=> stack_push && stack_push_data == $past(return_address))
		else $error("no push");
	a_no_low_in_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state == TLPI_HIGH && irq_request) |-> irq_vector == VEC_HIGH)
		else $error("low taken in high");
	a_latency_bound: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(high_pend && state == TLPI_IDLE && !irq_request && ext_wait == 2'h0
		&& !return_from_irq_instruction) ##1 (high_pend && !return_from_irq_instruction)[*2]
		|=> irq_request)
		else $error("latency too long");
	a_edge_rise: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(edge_and_priority_control[EP_EDG1] && $rose(ext_irq_pin1))
		|=> external_pin_interrupt_control[EX_P1IF])
		else $error("rising edge missed");
	a_pullup_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
		edge_and_priority_control[EP_PUDIS] |=> port_pullup_enable == 4'h0)
		else $error("pull-up active");
	a_return_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(return_from_irq_instruction && state == TLPI_LOW && reset_control_register[RC_PRIORITY_LEVELS_ENABLE]
		&& !irq_ack) |=> main_interrupt_control[MC_PERIPHERAL_IRQ_ENABLE])
		else $error("low enable not restored");
	c_high_taken: cover property (@(posedge sys_clk) irq_request && irq_ack && irq_vector == VEC_HIGH);
	c_low_taken: cover property (@(posedge sys_clk) irq_request && irq_ack && irq_vector == VEC_LOW);
	c_preempt: cover property (@(posedge sys_clk) state == TLPI_LOW && irq_request && irq_ack);
endmodule : tlpi_ctrl

// [tlpi_core_model.sv]
// Processor core model: takes interrupt requests and records what it vectored to
`timescale 1ns/1ps
module tlpi_core_model
	import tlpi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic irq_request,
	input wire logic [20:0] irq_vector,
	input wire logic [3:0] ack_delay,
	output logic irq_ack,
	output logic [20:0] return_address,
	output logic [20:0] last_vector,
	output logic [20:0] last_ret
);
	logic [3:0] wait_cnt;
	// A slow core lets the request stand for ack_delay extra cycles before taking it
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_ack <= 1'b0;
			wait_cnt <= 4'h0;
			return_address <= 21'h00_0100;
			last_vector <= 21'h00_0000;
			last_ret <= 21'h00_0000;
		end else begin
			return_address <= return_address + 21'h00_0002;
			if (irq_ack) begin
				irq_ack <= 1'b0;
				wait_cnt <= 4'h0;
			end else if (irq_request) begin
				if (wait_cnt >= ack_delay) begin
					irq_ack <= 1'b1;
					last_vector <= irq_vector;
					// Device samples the address seen on the acknowledge edge
					last_ret <= return_address + 21'h00_0002;
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end
		end
	end
endmodule : tlpi_core_model

// [tb_tlpi_ctrl.sv]
// Self-checking bench for the two-level priority interrupt unit
`timescale 1ns/1ps
module tb_tlpi_ctrl
	import tlpi_pkg::*;
;
	logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, rerr;
	logic timer0_overflow = 0, ext_irq_pin0 = 0, ext_irq_pin1 = 0, ext_irq_pin2 = 0;
	logic return_from_irq_instruction = 0, pready, pslverr, irq_ack, irq_request, stack_push;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
	logic [3:0] upper_port_b_pins = 4'h0, port_b_latch = 4'h0, port_pullup_enable;
	logic [3:0] ack_delay = 4'h0;
	logic [20:0] return_address, irq_vector, stack_push_data, last_vector, last_ret;
	int failures = 0, n_tests = 0, n;
	tlpi_ctrl dut (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .timer0_overflow, .ext_irq_pin0, .ext_irq_pin1, .ext_irq_pin2,
		.upper_port_b_pins, .port_b_latch, .irq_ack, .return_from_irq_instruction,
		.return_address, .irq_request, .irq_vector, .stack_push, .stack_push_data,
		.port_pullup_enable);
	tlpi_core_model core (.sys_clk, .reset_n, .irq_request, .irq_vector, .ack_delay,
		.irq_ack, .return_address, .last_vector, .last_ret);
	initial forever #50 sys_clk = ~sys_clk;
	function logic [20:0] exp_vec(input logic priority_levels_enable, input logic prio);
		return (priority_levels_enable && !prio) ? VEC_LOW : VEC_HIGH;
	endfunction : exp_vec
	function logic [3:0] exp_pull(input logic [3:0] latch, input logic dis);
		return dis ? 4'h0 : latch;
	endfunction : exp_pull
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	task done(input string s);
		$display("test %s finished", s);
	endtask : done
	// Bus master: holds the request until pready is seen high at an edge
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20)
			failures++;
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	task rchk(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk(rdat, {24'h00_0000, exp});
	endtask : rchk
	task tick_t0;
		timer0_overflow <= 1'b1;
		@(posedge sys_clk);
		timer0_overflow <= 1'b0;
		@(posedge sys_clk);
	endtask : tick_t0
	task ret_irq;
		return_from_irq_instruction <= 1'b1;
		@(posedge sys_clk);
		return_from_irq_instruction <= 1'b0;
		@(posedge sys_clk);
	endtask : ret_irq
	// Core acknowledges after a random stall; the push must carry its return address
	task service(input logic [20:0] vec);
		int k;
		k = 0;
		ack_delay <= 4'($urandom_range(0, 3));
		while (stack_push !== 1'b1 && k < 40) begin
			@(posedge sys_clk);
			k++;
		end
		if (k >= 40)
			failures++;
		chk(last_vector, vec);
		chk(stack_push_data, last_ret);
	endtask : service
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		end_sim;
	end
	initial begin
		n = $urandom(20472);
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		rchk(ADDR_MAIN_CTRL, 8'h00);
		rchk(ADDR_EDGE_PRIO, 8'hF5);
		rchk(ADDR_EXT_CTRL, 8'hC0);
		rchk(ADDR_RESET_CTRL, 8'h00);
		rchk(8'h18, 8'h00);
		chk(rerr, 1'b1);
		done("reset");
		tick_t0;
		rchk(ADDR_MAIN_CTRL, 8'h04);
		chk(irq_request, 1'b0);
		apb(1'b1, ADDR_MAIN_CTRL, 8'h00);
		rchk(ADDR_MAIN_CTRL, 8'h00);
		for (int e = 1; e >= 0; e--) begin
			apb(1'b1, ADDR_EDGE_PRIO, e ? 8'hF5 : 8'h85);
			for (int k = 0; k < 2; k++) begin
				{ext_irq_pin0, ext_irq_pin1, ext_irq_pin2} <= {3{~ext_irq_pin0}};
				repeat (3) @(posedge sys_clk);
				rchk(ADDR_MAIN_CTRL, (ext_irq_pin0 == e) ? 8'h02 : 8'h00);
				rchk(ADDR_EXT_CTRL, (ext_irq_pin0 == e) ? 8'hC3 : 8'hC0);
				apb(1'b1, ADDR_MAIN_CTRL, 8'h00);
				apb(1'b1, ADDR_EXT_CTRL, 8'hC0);
			end
		end
		done("flags");
		for (int k = 0; k < 4; k++) begin
			port_b_latch <= 4'($urandom);
			apb(1'b1, ADDR_EDGE_PRIO, k[0] ? 8'hF5 : 8'h75);
			@(posedge sys_clk);
			chk(port_pullup_enable, exp_pull(port_b_latch, k[0]));
		end
		apb(1'b0, ADDR_PORT_B, 8'h00);
		upper_port_b_pins <= 4'($urandom_range(1, 15));
		repeat (3) @(posedge sys_clk);
		rchk(ADDR_MAIN_CTRL, 8'h01);
		apb(1'b1, ADDR_MAIN_CTRL, 8'h00);
		rchk(ADDR_MAIN_CTRL, 8'h01);
		apb(1'b0, ADDR_PORT_B, 8'h00);
		apb(1'b1, ADDR_MAIN_CTRL, 8'h00);
		rchk(ADDR_MAIN_CTRL, 8'h00);
		done("port");
		apb(1'b1, ADDR_EDGE_PRIO, 8'hF1);
		apb(1'b1, ADDR_MAIN_CTRL, 8'hA0);
		tick_t0;
		service(exp_vec(1'b0, 1'b0));
		rchk(ADDR_MAIN_CTRL, 8'h24);
		apb(1'b1, ADDR_MAIN_CTRL, 8'h20);
		ret_irq;
		rchk(ADDR_MAIN_CTRL, 8'hA0);
		apb(1'b1, ADDR_MAIN_CTRL, 8'h90);
		ext_irq_pin0 <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (irq_request !== 1'b1 && n < 20);
		chk(n >= 4 && n <= 5, 1'b1);
		service(exp_vec(1'b0, 1'b0));
		apb(1'b1, ADDR_MAIN_CTRL, 8'h10);
		ret_irq;
		ext_irq_pin0 <= 1'b0;
		done("compat");
		apb(1'b1, ADDR_RESET_CTRL, 8'h80);
		apb(1'b1, ADDR_MAIN_CTRL, 8'h60);
		tick_t0;
		repeat (8) @(posedge sys_clk);
		chk(irq_request, 1'b0);
		apb(1'b1, ADDR_MAIN_CTRL, 8'hE4);
		service(exp_vec(1'b1, 1'b0));
		rchk(ADDR_MAIN_CTRL, 8'hA4);
		rchk(ADDR_STATUS, 8'h02);
		apb(1'b1, ADDR_MAIN_CTRL, 8'hB4);
		ext_irq_pin0 <= 1'b1;
		service(exp_vec(1'b1, 1'b1));
		rchk(ADDR_STATUS, 8'h04);
		apb(1'b1, ADDR_MAIN_CTRL, 8'h74);
		repeat (8) @(posedge sys_clk);
		chk(irq_request, 1'b0);
		apb(1'b1, ADDR_MAIN_CTRL, 8'h34);
		ret_irq;
		rchk(ADDR_MAIN_CTRL, 8'hB4);
		rchk(ADDR_STATUS, 8'h02);
		apb(1'b1, ADDR_MAIN_CTRL, 8'hB0);
		ret_irq;
		rchk(ADDR_MAIN_CTRL, 8'hF0);
		ext_irq_pin0 <= 1'b0;
		@(posedge sys_clk);
		timer0_overflow <= 1'b1;
		ext_irq_pin0 <= 1'b1;
		@(posedge sys_clk);
		timer0_overflow <= 1'b0;
		service(exp_vec(1'b1, 1'b1));
		apb(1'b1, ADDR_MAIN_CTRL, 8'h74);
		ret_irq;
		service(exp_vec(1'b1, 1'b0));
		apb(1'b1, ADDR_MAIN_CTRL, 8'hB0);
		ret_irq;
		rchk(ADDR_MAIN_CTRL, 8'hF0);
		done("priority");
		end_sim;
	end
endmodule : tb_tlpi_ctrl
